// *** hdl/bsv_regs.svh ***
// Register indices, field positions and reset values of the battery saver block.
// Assumes a 32-bit Avalon-MM slave; byte address is four times the index.
`ifndef BSV_REGS_SVH
`define BSV_REGS_SVH

// ==========================================================
// Register indices
`define BSV_IDX_CFG       6'h09
`define BSV_IDX_THR_ONE   6'h0a
`define BSV_IDX_THR_TWO   6'h0b
`define BSV_IDX_IRQ_STAT  6'h10
`define BSV_IDX_IRQ_MASK  6'h11
`define BSV_IDX_STATE     6'h12

// ==========================================================
// Reset values
`define BSV_RST_CFG       8'h00
`define BSV_RST_THR_ONE   8'h92
`define BSV_RST_THR_TWO   8'h8d
`define BSV_RST_IRQ       3'h0

// ==========================================================
// Field positions
`define BSV_CFG_EN_MSB    7
`define BSV_CFG_EN_LSB    6
`define BSV_CFG_UV_MSB    2
`define BSV_CFG_UV_LSB    0
`define BSV_IRQ_UV        0
`define BSV_IRQ_ONE       1
`define BSV_IRQ_TWO       2
`define BSV_IRQ_BITS      3

// ==========================================================
// Supply comparator bank: trip level k is 2.5 V + k * 0.1 V
`define BSV_UV_LEVELS     8
`define BSV_SUPPLY_BITS   8

`endif

// *** hdl/bsv_pkg.sv ***
// Types shared by the battery saver block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package bsv_pkg;

  typedef enum logic [1:0] {
    BSV_ST_STANDBY = 2'b00,
    BSV_ST_ACTIVE  = 2'b01
  } bsv_state_t;

  typedef enum logic [1:0] {
    BSV_CLAMP_NONE = 2'b00,
    BSV_CLAMP_ONE  = 2'b01,
    BSV_CLAMP_TWO  = 2'b10
  } bsv_clamp_t;

endpackage

`default_nettype wire

// *** hdl/bsv_sync_if.sv ***
// Carrier between the core and its pin synchroniser.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface bsv_sync_if #(
  parameter int W = 16
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface

`default_nettype wire

// *** hdl/bsv_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a slowly moving level; buses are not made coherent.
`timescale 1ns/1ps
`default_nettype none

module bsv_sync #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  bsv_sync_if.snk  port
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = port.raw;
    sync_next = meta_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign port.sync = sync_reg;
endmodule

`default_nettype wire

// *** hdl/bsv_core.sv ***
// Battery saver and undervoltage lockout: registers, clamp choice, lockout.
// Assumes effect_start/effect_end are one-cycle pulses on sys_clk and the
// overdrive limits come from registers on the same clock.
`include "bsv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bsv_core (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic [7:0]  supply_level_in,
  input  wire logic [7:0]  uv_below_in,
  input  wire logic        effect_start,
  input  wire logic        effect_end,
  input  wire logic [7:0]  od_limit_one,
  input  wire logic [7:0]  od_limit_two,
  output var  logic        out_stage_en,
  output var  logic        standby,
  output var  logic [1:0]  od_clamp_sel,
  output var  logic [7:0]  od_clamp,
  output var  logic        effect_abort,
  output var  logic        irq
);
  localparam int SW = `BSV_SUPPLY_BITS;
  localparam int NL = `BSV_UV_LEVELS;
  localparam int IB = `BSV_IRQ_BITS;

  // ==========================================================
  // Pin synchroniser
  bsv_sync_if #(.W(SW + NL)) pins ();

  assign pins.raw = {supply_level_in, uv_below_in};

  bsv_sync #(.W(SW + NL)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .port    (pins)
  );

  logic [SW-1:0] supply_s;
  logic [NL-1:0] uv_s;
  assign supply_s = pins.sync[SW+NL-1:NL];
  assign uv_s     = pins.sync[NL-1:0];

  // ==========================================================
  // Bus slave: one wait cycle on every access
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic [7:0]  thr_one_reg;
  logic [7:0]  thr_one_next;
  logic [7:0]  thr_two_reg;
  logic [7:0]  thr_two_next;
  logic [IB-1:0] stat_reg;
  logic [IB-1:0] stat_next;
  logic [IB-1:0] mask_reg;
  logic [IB-1:0] mask_next;
  logic [IB-1:0] stat_set;
  logic        irq_reg;
  logic        irq_next;

  logic [5:0]  idx;
  logic        word_ok;
  logic        wr_go;
  logic        lane0;

  bsv_pkg::bsv_state_t state_reg;
  bsv_pkg::bsv_state_t state_next;
  bsv_pkg::bsv_clamp_t sel_reg;
  bsv_pkg::bsv_clamp_t sel_next;

  assign idx     = avs_address[7:2];
  assign word_ok = (avs_address[1:0] == 2'b00);
  // Write takes effect at the edge where the master sees waitrequest low
  assign wr_go   = avs_write && !wait_reg && word_ok;
  assign lane0   = avs_byteenable[0];

  always_comb begin
    wait_next    = !((avs_read || avs_write) && wait_reg);
    rdata_next   = rdata_reg;
    cfg_next     = cfg_reg;
    thr_one_next = thr_one_reg;
    thr_two_next = thr_two_reg;
    mask_next    = mask_reg;
    if (avs_read && wait_reg) begin
      rdata_next = 32'h0000_0000;
      if (word_ok) begin
        case (idx)
          `BSV_IDX_CFG:      rdata_next[7:0] = cfg_reg;
          `BSV_IDX_THR_ONE:  rdata_next[7:0] = thr_one_reg;
          `BSV_IDX_THR_TWO:  rdata_next[7:0] = thr_two_reg;
          `BSV_IDX_IRQ_STAT: rdata_next[IB-1:0] = stat_reg;
          `BSV_IDX_IRQ_MASK: rdata_next[IB-1:0] = mask_reg;
          `BSV_IDX_STATE:    rdata_next[4:0] = {uv_s[cfg_reg[`BSV_CFG_UV_MSB:`BSV_CFG_UV_LSB]],
                                                 state_reg == bsv_pkg::BSV_ST_ACTIVE,
                                                 out_stage_en, sel_reg};
          default:           rdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (wr_go && lane0) begin
      case (idx)
        `BSV_IDX_CFG:      cfg_next = avs_writedata[7:0];
        `BSV_IDX_THR_ONE:  thr_one_next = avs_writedata[7:0];
        `BSV_IDX_THR_TWO:  thr_two_next = avs_writedata[7:0];
        `BSV_IDX_IRQ_MASK: mask_next = avs_writedata[IB-1:0];
        default:           mask_next = mask_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      cfg_reg     <= `BSV_RST_CFG;
      thr_one_reg <= `BSV_RST_THR_ONE;
      thr_two_reg <= `BSV_RST_THR_TWO;
      mask_reg    <= `BSV_RST_IRQ;
    end else begin
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
      cfg_reg     <= cfg_next;
      thr_one_reg <= thr_one_next;
      thr_two_reg <= thr_two_next;
      mask_reg    <= mask_next;
    end
  end

  // ==========================================================
  // Field decode
  logic [1:0] lvl_en;
  logic [2:0] uv_code;
  logic       en_one;
  logic       en_two;
  logic       uv_below;

  assign lvl_en   = cfg_reg[`BSV_CFG_EN_MSB:`BSV_CFG_EN_LSB];
  assign uv_code  = cfg_reg[`BSV_CFG_UV_MSB:`BSV_CFG_UV_LSB];
  assign en_one   = (lvl_en != 2'b00);
  assign en_two   = lvl_en[1];
  assign uv_below = uv_s[uv_code];

  // ==========================================================
  // Effect state, clamp choice and lockout
  logic [7:0] clamp_reg;
  logic [7:0] clamp_next;
  logic       stage_reg;
  logic       stage_next;
  logic       abort_reg;
  logic       abort_next;
  // Own flop so the standby pin is not a decode of the state bits
  logic       standby_reg;
  logic       standby_next;

  always_comb begin
    state_next = state_reg;
    sel_next   = sel_reg;
    clamp_next = clamp_reg;
    stage_next = stage_reg;
    abort_next = 1'b0;
    stat_set   = '0;
    case (state_reg)
      bsv_pkg::BSV_ST_STANDBY: begin
        if (effect_start && uv_below) begin
          stat_set[`BSV_IRQ_UV] = 1'b1;
        end else if (effect_start) begin
          state_next = bsv_pkg::BSV_ST_ACTIVE;
          stage_next = 1'b1;
          // Supply is looked at only here, then held for the effect
          if (en_two && supply_s < thr_two_reg) begin
            sel_next   = bsv_pkg::BSV_CLAMP_TWO;
            clamp_next = od_limit_two;
            stat_set[`BSV_IRQ_TWO] = 1'b1;
          end else if (en_one && supply_s < thr_one_reg) begin
            sel_next   = bsv_pkg::BSV_CLAMP_ONE;
            clamp_next = od_limit_one;
            stat_set[`BSV_IRQ_ONE] = 1'b1;
          end else begin
            sel_next   = bsv_pkg::BSV_CLAMP_NONE;
            clamp_next = 8'h00;
          end
        end
      end
      bsv_pkg::BSV_ST_ACTIVE: begin
        if (uv_below || effect_end) begin
          state_next = bsv_pkg::BSV_ST_STANDBY;
          stage_next = 1'b0;
          sel_next   = bsv_pkg::BSV_CLAMP_NONE;
          clamp_next = 8'h00;
          abort_next = uv_below;
          stat_set[`BSV_IRQ_UV] = uv_below;
        end
      end
      default: begin
        state_next = bsv_pkg::BSV_ST_STANDBY;
        stage_next = 1'b0;
      end
    endcase
    standby_next = (state_next == bsv_pkg::BSV_ST_STANDBY);
  end

  // Set beats a same-cycle write-one clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_go && lane0 && idx == `BSV_IDX_IRQ_STAT) begin
      stat_next = stat_reg & ~avs_writedata[IB-1:0];
    end
    stat_next = stat_next | stat_set;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= bsv_pkg::BSV_ST_STANDBY;
      sel_reg   <= bsv_pkg::BSV_CLAMP_NONE;
      clamp_reg <= 8'h00;
      stage_reg <= 1'b0;
      abort_reg <= 1'b0;
      standby_reg <= 1'b1;
      stat_reg  <= `BSV_RST_IRQ;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg   <= sel_next;
      clamp_reg <= clamp_next;
      stage_reg <= stage_next;
      abort_reg <= abort_next;
      standby_reg <= standby_next;
      stat_reg  <= stat_next;
      irq_reg   <= irq_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign out_stage_en    = stage_reg;
  assign standby         = standby_reg;
  assign od_clamp_sel    = sel_reg;
  assign od_clamp        = clamp_reg;
  assign effect_abort    = abort_reg;
  assign irq             = irq_reg;

  // ==========================================================
  // Checks
  logic start_ok;
  assign start_ok = effect_start && !uv_below && state_reg == bsv_pkg::BSV_ST_STANDBY;

  a_lvl_off_none: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok && lvl_en == 2'b00 |=> sel_reg == bsv_pkg::BSV_CLAMP_NONE)
    else $error("clamp chosen with saver disabled");

  a_uv_code_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg == bsv_pkg::BSV_ST_ACTIVE && !uv_s[uv_code] && !effect_end
    |=> state_reg == bsv_pkg::BSV_ST_ACTIVE)
    else $error("lockout without selected trip level");

  a_uv_stage_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg == bsv_pkg::BSV_ST_ACTIVE && uv_below
    |=> !out_stage_en && standby && effect_abort ##1 !effect_abort)
    else $error("output stage not cut on undervoltage");

  a_lvl_one_pick: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok && lvl_en == 2'b01 && supply_s < thr_one_reg
    |=> sel_reg == bsv_pkg::BSV_CLAMP_ONE && od_clamp == $past(od_limit_one))
    else $error("limit one not applied");

  a_lvl_two_pick: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok && lvl_en == 2'b10 && supply_s < thr_two_reg
    |=> sel_reg == bsv_pkg::BSV_CLAMP_TWO && od_clamp == $past(od_limit_two))
    else $error("limit two not applied");

  a_clamp_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_reg == bsv_pkg::BSV_ST_ACTIVE && !uv_below && !effect_end
    |=> $stable(od_clamp_sel) && $stable(od_clamp))
    else $error("clamp changed during effect");

  a_two_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok && en_two && supply_s < thr_one_reg && supply_s < thr_two_reg
    |=> sel_reg == bsv_pkg::BSV_CLAMP_TWO)
    else $error("limit one won over limit two");

  a_en3_as_two: assert property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok && lvl_en == 2'b11 && supply_s < thr_two_reg
    |=> sel_reg == bsv_pkg::BSV_CLAMP_TWO)
    else $error("enable code 3 not treated as 2");

  a_cfg_keeps_rsv: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_go && lane0 && idx == `BSV_IDX_CFG |=> cfg_reg == $past(avs_writedata[7:0]))
    else $error("config write not kept whole");

  a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    |(stat_set & mask_reg) && !(wr_go && lane0 && idx == `BSV_IDX_IRQ_MASK)
    |=> irq && (stat_reg & mask_reg) != '0)
    else $error("interrupt not raised by unmasked event");

  c_lvl_one: cover property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok ##1 sel_reg == bsv_pkg::BSV_CLAMP_ONE);
  c_lvl_two: cover property (@(posedge sys_clk) disable iff (!rst_b)
    start_ok ##1 sel_reg == bsv_pkg::BSV_CLAMP_TWO);
  c_uv_abort: cover property (@(posedge sys_clk) disable iff (!rst_b) effect_abort);
  c_irq_up: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(irq));
endmodule

`default_nettype wire

// *** bench/bsv_host.sv ***
// Host model: Avalon-MM master through which software reaches the registers.
// Assumes a slave that answers by dropping waitrequest; no fixed count assumed.
`timescale 1ns/1ps
`default_nettype none

module bsv_host (
  input  wire logic        sys_clk,
  output var  logic [7:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // ====
  // Bus cycles
  // Request held until waitrequest is sampled low; only the bench timeout ends it
  task automatic await_ack();
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address    <= a;
    avs_writedata  <= 32'(d);
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    await_ack();
    avs_write      <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    avs_address    <= a;
    avs_byteenable <= 4'hf;
    avs_read       <= 1'b1;
    await_ack();
    d = avs_readdata[7:0];
    avs_read       <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** bench/test_battery_saver_undervoltage_cfg.sv ***
// Self-checking bench for the battery saver and undervoltage lockout core.
// Assumes bsv_core as design top and bsv_host as the register bus master.
`include "bsv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_battery_saver_undervoltage_cfg;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  supply_level_in = 8'h00;
  logic [7:0]  uv_below_in = 8'h00;
  logic        effect_start = 1'b0;
  logic        effect_end = 1'b0;
  logic [7:0]  lim1 = 8'h60;
  logic [7:0]  lim2 = 8'h40;
  logic        out_stage_en;
  logic        standby;
  logic [1:0]  od_clamp_sel;
  logic [7:0]  od_clamp;
  logic        effect_abort;
  logic        irq;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [7:0]  d;
  logic [7:0]  ec;
  logic        seen;
  localparam logic [7:0] CFG = {`BSV_IDX_CFG, 2'b00};
  localparam logic [7:0] THR1 = {`BSV_IDX_THR_ONE, 2'b00};
  localparam logic [7:0] THR2 = {`BSV_IDX_THR_TWO, 2'b00};
  localparam logic [7:0] STAT = {`BSV_IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] MASK = {`BSV_IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] STATE = {`BSV_IDX_STATE, 2'b00};
  // Supply cases against default thresholds 146 and 141, edges included
  logic [1:0]         c_en  [8] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2};
  logic [7:0]         c_sup [8] = '{8'h64, 8'h91, 8'h92, 8'h64, 8'h8c, 8'h8f, 8'h8c, 8'h8d};
  bsv_pkg::bsv_clamp_t c_sel [8] = '{bsv_pkg::BSV_CLAMP_NONE, bsv_pkg::BSV_CLAMP_ONE,
    bsv_pkg::BSV_CLAMP_NONE, bsv_pkg::BSV_CLAMP_ONE, bsv_pkg::BSV_CLAMP_TWO,
    bsv_pkg::BSV_CLAMP_ONE, bsv_pkg::BSV_CLAMP_TWO, bsv_pkg::BSV_CLAMP_ONE};

  always #50 sys_clk = ~sys_clk;

  bsv_host HOST (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  bsv_core DUT (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .supply_level_in(supply_level_in),
    .uv_below_in(uv_below_in), .effect_start(effect_start), .effect_end(effect_end),
    .od_limit_one(lim1), .od_limit_two(lim2), .out_stage_en(out_stage_en),
    .standby(standby), .od_clamp_sel(od_clamp_sel), .od_clamp(od_clamp),
    .effect_abort(effect_abort), .irq(irq));

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One-cycle start or end pulse; outputs looked at once they have settled
  task automatic fire(input logic st);
    @(posedge sys_clk);
    if (st) effect_start <= 1'b1;
    else effect_end <= 1'b1;
    @(posedge sys_clk);
    effect_start <= 1'b0;
    effect_end <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    HOST.rd(a, v);
    `CHK("register", e, v)
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rchk(CFG, 8'h00);
    rchk(THR1, 8'h92);
    rchk(THR2, 8'h8d);
    rchk(8'h3c, 8'h00);
    rchk(8'h25, 8'h00);
    HOST.wr(THR1, 8'h55, 4'h0);
    rchk(THR1, 8'h92);
    HOST.wr(CFG, 8'hff, 4'hf);
    rchk(CFG, 8'hff);
    // ====
    // Clamp choice per enable code and supply
    for (int i = 0; i < 8; i++) begin
      HOST.wr(CFG, {c_en[i], 6'h00}, 4'hf);
      supply_level_in <= c_sup[i];
      repeat (4) @(posedge sys_clk);
      fire(1'b1);
      ec = (c_sel[i] == bsv_pkg::BSV_CLAMP_ONE) ? lim1 :
           (c_sel[i] == bsv_pkg::BSV_CLAMP_TWO) ? lim2 : 8'h00;
      `CHK("clamp select", c_sel[i], od_clamp_sel)
      `CHK("clamp value", ec, od_clamp)
      `CHK("stage on", 1'b0, standby)
      @(posedge sys_clk);
      supply_level_in <= 8'h00;
      repeat (5) @(negedge sys_clk);
      `CHK("clamp held", ec, od_clamp)
      rchk(STATE, {3'b000, 3'b011, c_sel[i]});
      fire(1'b0);
      `CHK("clamp cleared", 2'h0, od_clamp_sel)
    end
    // ====
    // Sticky status, mask and level interrupt
    rchk(STAT, 8'h06);
    `CHK("irq masked", 1'b0, irq)
    HOST.wr(MASK, 8'h07, 4'hf);
    repeat (2) @(negedge sys_clk);
    `CHK("irq raised", 1'b1, irq)
    rchk(MASK, 8'h07);
    HOST.wr(STAT, 8'h06, 4'hf);
    rchk(STAT, 8'h00);
    `CHK("irq cleared", 1'b0, irq)
    // ====
    // Each trip code refuses at its own level; for codes 1 to 7 the code one lower then accepts
    for (int k = 0; k < 8; k++) begin
      HOST.wr(CFG, 8'(k), 4'hf);
      uv_below_in <= 8'hff << k;
      repeat (4) @(posedge sys_clk);
      fire(1'b1);
      `CHK("start refused", 1'b1, standby)
      if (k > 0) begin
        HOST.wr(CFG, 8'(k - 1), 4'hf);
        fire(1'b1);
        `CHK("start taken", 1'b1, out_stage_en)
        fire(1'b0);
      end
    end
    rchk(STAT, 8'h01);
    `CHK("irq lockout", 1'b1, irq)
    HOST.wr(STAT, 8'h01, 4'hf);
    // Supply collapses in mid-effect
    uv_below_in <= 8'h00;
    HOST.wr(CFG, 8'h03, 4'hf);
    repeat (4) @(posedge sys_clk);
    fire(1'b1);
    `CHK("stage on", 1'b1, out_stage_en)
    @(posedge sys_clk);
    uv_below_in <= 8'hf8;
    seen = 1'b0;
    for (int j = 0; j < 8 && !seen; j++) begin
      @(negedge sys_clk);
      seen = (effect_abort === 1'b1);
    end
    `CHK("abort", 1'b1, seen)
    `CHK("stage off", 1'b0, out_stage_en)
    `CHK("standby", 1'b1, standby)
    `CHK("irq abort", 1'b1, irq)
    rchk(STATE, 8'h10);
    // Reset in mid-run returns every register and output to its idle value
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("reset irq", 1'b0, irq)
    `CHK("reset standby", 1'b1, standby)
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rchk(MASK, 8'h00);
    rchk(STAT, 8'h00);
    rchk(CFG, 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
